// file: hw/tsm_pkg.sv
// Shared constants and carrier types of the test signal output mux.
// Assumes one 100 MHz core clock and observation sources on that clock.
// Operation
// RULE1: Receive queue byte at 0x3F, read/write, resets zero.
// RULE2: Host accesses queue only with oscillator running.
// RULE3: Each pin has own code; 0 is normal.
// RULE4: Code 1 gives ADC Q / I LSB.
// RULE5: Clear-channel code 2 pulses on late resync.
// RULE6: Frame-delimiter code 2 pulses on early resync.
// RULE7: Code 3 mirrors synthesizer lock status.
// RULE8: Clear-channel codes 4/5: chip/bit clocks in transmit.
// RULE9: Frame-delimiter codes 4/5: chip/bit data in transmit.
// RULE10: Codes 6-11 give active-high power-down controls.
// RULE11: Clear-channel code 12 pulses on gain update.
// RULE12: Codes 12-14 select VGA peak detector stages.
// RULE13: Codes 15/16 give gain mode, VGA gain bits.
// RULE14: Clear-channel code 17 gives peak-detector reset, active low.
// RULE15: Frame-delimiter code 17 gives bandpass calibration clock.
// RULE16: Clear-channel code 23 gives 8 MHz; others reserved.
// RULE17: Clear-channel code 24 gives crystal stable flag.
// RULE18: Frame-delimiter code 24 gives frequency comparator.
// RULE19: Codes 25-28 give synthesizer reference, feedback, windows.
// RULE20: Code 29 ADC clock; 30 low; 31 high.
// RULE21: Reserved codes drive the pin low.

package tsm_pkg;

	// Register map
	localparam logic [5:0] REG_RXQ_ADDR = 6'h3f;
	localparam logic [7:0] RXQ_RESET = 8'h00;
	localparam logic [7:0] RDATA_RESET = 8'h00;

	// Select codes that matter to more than one branch
	localparam logic [4:0] CODE_NORMAL = 5'h00;
	localparam logic [4:0] CODE_ADC_LSB = 5'h01;
	localparam logic [4:0] CODE_RESYNC = 5'h02;
	localparam logic [4:0] CODE_LOCK = 5'h03;
	localparam logic [4:0] CODE_TX_CHIP = 5'h04;
	localparam logic [4:0] CODE_TX_BIT = 5'h05;
	localparam logic [4:0] CODE_PD_FIRST = 5'h06;
	localparam logic [4:0] CODE_CLK8 = 5'h17;
	localparam logic [4:0] CODE_LOW = 5'h1e;
	localparam logic [4:0] CODE_HIGH = 5'h1f;

	// Timing: core clock and the 16 MHz pulse / tick reference
	localparam int CORE_PERIOD_PS = 10000;
	localparam int TICK_PERIOD_PS = 62500;
	localparam int CORE_CLK_KHZ = 100000;
	localparam int TICK_CLK_KHZ = 16000;
	// One 16 MHz cycle as core cycles, rounded up so the pulse is never short
	localparam logic [2:0] PULSE_CYCLES =
		3'((TICK_PERIOD_PS + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS);
	localparam logic [16:0] ACC_STEP = 17'(TICK_CLK_KHZ);
	localparam logic [16:0] ACC_WRAP = 17'(CORE_CLK_KHZ);
	localparam logic [16:0] ACC_RESET = 17'h00000;
	localparam logic [2:0] CNT_RESET = 3'h0;

	// Register request from the configuration port
	typedef struct packed {
		logic rd;
		logic wr;
		logic [5:0] addr;
		logic [7:0] wdata;
	} tsm_reg_req_type;

	// Internal signals that may be observed on the pins
	typedef struct packed {
		logic adc_q_lsb;
		logic adc_i_lsb;
		logic demod_late_resync_pulse;
		logic demod_early_resync_pulse;
		logic synth_locked_flag;
		logic tx_active;
		logic tx_chip_rate_clock;
		logic tx_bit_rate_clock;
		logic tx_chip_stream;
		logic tx_bit_stream;
		logic [5:0] power_down;
		logic gain_update_pulse;
		logic [4:0] peak_det;
		logic [1:0] frontend_gain_mode;
		logic [1:0] vga_gain;
		logic peak_det_reset_n;
		logic bandpass_cal_clock;
		logic crystal_stable_flag;
		logic synth_freq_compare;
		logic synth_reference_signal;
		logic synth_divided_signal;
		logic synth_lock_window;
		logic synth_lock_window_sync;
		logic converter_clock_one;
		logic converter_clock_two;
	} tsm_obs_type;

	// State of one pin selector
	typedef struct packed {
		logic pin;
	} tsm_mux_state_type;

	// State of the top block
	typedef struct packed {
		logic [7:0] rxq;
		logic [7:0] rdata;
		logic rvalid;
		logic pop;
		logic [2:0] late_cnt;
		logic [2:0] early_cnt;
		logic [2:0] agc_cnt;
		logic [16:0] acc;
		logic clk8;
	} tsm_state_type;

endpackage

// file: hw/tsm_pin_mux.sv
// One registered 32-way selector driving a single test output pin.
// Assumes the caller has already zeroed the source bits of reserved codes.
`timescale 1ns/1ns
`default_nettype none

module tsm_pin_mux
	import tsm_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic resetn_i,
	// Selection
	input wire logic [4:0] sel_i,
	input wire logic [31:0] src_i,
	// Pin
	output logic pin_o
);

	tsm_mux_state_type state_q; // Registered pin level
	tsm_mux_state_type state_d; // Next pin level

	// Pick the source named by the code
	always_comb
	begin
		state_d = state_q;
		state_d.pin = src_i[sel_i]; // [RULE3]
	end

	// Register so the pin never glitches while the code changes
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			state_q <= '0;
		else
			state_q <= state_d;
	end

	assign pin_o = state_q.pin;

	// Pin follows the selected source one cycle later
	a_pin_tracks_source: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RULE3]
		1'b1 |=> pin_o == $past(src_i[sel_i]))
		else $error("pin does not follow selected source");

endmodule

`default_nettype wire

// file: hw/tsm_top.sv
// Test signal output mux with the receive queue byte register.
// Assumes every observed source and the register port run on core_clk_i.
`timescale 1ns/1ns
`default_nettype none

module tsm_top
	import tsm_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic resetn_i,
	// Register port
	input wire tsm_reg_req_type reg_req_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// Receive data path side of the queue byte
	input wire logic rxq_load_i,
	input wire logic [7:0] rxq_load_byte_i,
	output logic rxq_pop_o,
	// Pin select codes from the I/O configuration
	input wire logic [4:0] clear_channel_pin_select_i,
	input wire logic [4:0] frame_delimiter_pin_select_i,
	// Normal pin functions
	input wire logic clear_channel_i,
	input wire logic frame_delimiter_i,
	// Observed internal signals
	input wire tsm_obs_type obs_i,
	// Output pins
	output logic clear_channel_pin_o,
	output logic frame_delimiter_pin_o
);

	tsm_state_type state_q; // All registered state
	tsm_state_type state_d; // Next state
	logic [31:0] cca_src; // Sources per code, clear-channel pin
	logic [31:0] sfd_src; // Sources per code, frame-delimiter pin
	logic access_ok; // Oscillator is running, accesses are honoured
	logic hit_rxq; // Request addresses the queue byte
	logic late_str; // Stretched late-resync pulse
	logic early_str; // Stretched early-resync pulse
	logic agc_str; // Stretched gain-update pulse
	logic [16:0] acc_sum; // Phase accumulator before wrap

	assign access_ok = obs_i.crystal_stable_flag; // [RULE2]
	assign hit_rxq = reg_req_i.addr == REG_RXQ_ADDR;
	assign late_str = state_q.late_cnt != CNT_RESET;
	assign early_str = state_q.early_cnt != CNT_RESET;
	assign agc_str = state_q.agc_cnt != CNT_RESET;
	assign acc_sum = state_q.acc + ACC_STEP;

	// Next-state logic: register port, pulse stretchers, 8 MHz divider
	always_comb
	begin
		state_d = state_q;
		state_d.rvalid = 1'b0;
		state_d.pop = 1'b0;
		// Accesses without the oscillator are dropped with no answer
		if (access_ok) // [RULE2]
		begin
			if (reg_req_i.wr && hit_rxq)
				state_d.rxq = reg_req_i.wdata; // [RULE1]
			if (reg_req_i.rd)
			begin
				state_d.rvalid = 1'b1;
				// Unmapped addresses read as zero
				state_d.rdata = hit_rxq ? state_q.rxq : RDATA_RESET; // [RULE1]
				state_d.pop = hit_rxq;
			end
		end
		// A byte from the receive path wins so no received data is lost
		if (rxq_load_i)
			state_d.rxq = rxq_load_byte_i;
		// Stretch one-cycle strobes to one 16 MHz period; a retrigger restarts
		if (obs_i.demod_late_resync_pulse)
			state_d.late_cnt = PULSE_CYCLES; // [RULE5]
		else if (late_str)
			state_d.late_cnt = state_q.late_cnt - 3'h1;
		if (obs_i.demod_early_resync_pulse)
			state_d.early_cnt = PULSE_CYCLES; // [RULE6]
		else if (early_str)
			state_d.early_cnt = state_q.early_cnt - 3'h1;
		if (obs_i.gain_update_pulse)
			state_d.agc_cnt = PULSE_CYCLES; // [RULE11]
		else if (agc_str)
			state_d.agc_cnt = state_q.agc_cnt - 3'h1;
		// Fractional divider: 16 MHz ticks from 100 MHz; the 8 MHz clock
		// toggles per tick, so its edges jitter by one core cycle
		if (acc_sum >= ACC_WRAP)
		begin
			state_d.acc = acc_sum - ACC_WRAP;
			state_d.clk8 = ~state_q.clk8; // [RULE16]
		end
		else
			state_d.acc = acc_sum;
	end

	// State register
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_q.rxq <= RXQ_RESET; // [RULE1]
			state_q.rdata <= RDATA_RESET;
			state_q.rvalid <= 1'b0;
			state_q.pop <= 1'b0;
			state_q.late_cnt <= CNT_RESET;
			state_q.early_cnt <= CNT_RESET;
			state_q.agc_cnt <= CNT_RESET;
			state_q.acc <= ACC_RESET;
			state_q.clk8 <= 1'b0;
		end
		else
			state_q <= state_d;
	end

	assign reg_rdata_o = state_q.rdata;
	assign reg_rvalid_o = state_q.rvalid;
	assign rxq_pop_o = state_q.pop;

	// Source table of the clear-channel pin; reserved codes stay zero
	always_comb
	begin
		cca_src = '0; // [RULE21]
		cca_src[0] = clear_channel_i; // [RULE3]
		cca_src[1] = obs_i.adc_q_lsb; // [RULE4]
		cca_src[2] = late_str; // [RULE5]
		cca_src[3] = obs_i.synth_locked_flag; // [RULE7]
		cca_src[4] = obs_i.tx_active & obs_i.tx_chip_rate_clock; // [RULE8]
		cca_src[5] = obs_i.tx_active & obs_i.tx_bit_rate_clock; // [RULE8]
		cca_src[11:6] = obs_i.power_down; // [RULE10]
		cca_src[12] = agc_str; // [RULE11]
		cca_src[13] = obs_i.peak_det[1]; // [RULE12]
		cca_src[14] = obs_i.peak_det[3]; // [RULE12]
		cca_src[15] = obs_i.frontend_gain_mode[1]; // [RULE13]
		cca_src[16] = obs_i.vga_gain[1]; // [RULE13]
		cca_src[17] = obs_i.peak_det_reset_n; // [RULE14]
		cca_src[23] = state_q.clk8; // [RULE16]
		cca_src[24] = obs_i.crystal_stable_flag; // [RULE17]
		cca_src[25] = obs_i.synth_reference_signal; // [RULE19]
		cca_src[26] = obs_i.synth_divided_signal; // [RULE19]
		cca_src[27] = obs_i.synth_lock_window; // [RULE19]
		cca_src[28] = obs_i.synth_lock_window_sync; // [RULE19]
		cca_src[29] = obs_i.converter_clock_one; // [RULE20]
		cca_src[30] = 1'b0; // [RULE20]
		cca_src[31] = 1'b1; // [RULE20]
	end

	// Source table of the frame-delimiter pin; reserved codes stay zero
	always_comb
	begin
		sfd_src = '0; // [RULE21]
		sfd_src[0] = frame_delimiter_i; // [RULE3]
		sfd_src[1] = obs_i.adc_i_lsb; // [RULE4]
		sfd_src[2] = early_str; // [RULE6]
		sfd_src[3] = obs_i.synth_locked_flag; // [RULE7]
		sfd_src[4] = obs_i.tx_active & obs_i.tx_chip_stream; // [RULE9]
		sfd_src[5] = obs_i.tx_active & obs_i.tx_bit_stream; // [RULE9]
		sfd_src[11:6] = obs_i.power_down; // [RULE10]
		sfd_src[12] = obs_i.peak_det[0]; // [RULE12]
		sfd_src[13] = obs_i.peak_det[2]; // [RULE12]
		sfd_src[14] = obs_i.peak_det[4]; // [RULE12]
		sfd_src[15] = obs_i.frontend_gain_mode[0]; // [RULE13]
		sfd_src[16] = obs_i.vga_gain[0]; // [RULE13]
		sfd_src[17] = obs_i.bandpass_cal_clock; // [RULE15]
		sfd_src[24] = obs_i.synth_freq_compare; // [RULE18]
		sfd_src[25] = obs_i.synth_reference_signal; // [RULE19]
		sfd_src[26] = obs_i.synth_divided_signal; // [RULE19]
		sfd_src[27] = obs_i.synth_lock_window; // [RULE19]
		sfd_src[28] = obs_i.synth_lock_window_sync; // [RULE19]
		sfd_src[29] = obs_i.converter_clock_two; // [RULE20]
		sfd_src[30] = 1'b0; // [RULE20]
		sfd_src[31] = 1'b1; // [RULE20]
	end

	// Clear-channel pin selector
	tsm_pin_mux u_cca_mux (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.sel_i(clear_channel_pin_select_i),
		.src_i(cca_src),
		.pin_o(clear_channel_pin_o)
	);

	// Frame-delimiter pin selector
	tsm_pin_mux u_sfd_mux (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.sel_i(frame_delimiter_pin_select_i),
		.src_i(sfd_src),
		.pin_o(frame_delimiter_pin_o)
	);

	// Checks
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);

	// A queue write is readable back by a read in the next cycle
	a_rxq_write_read: assert property ( // [RULE1]
		(reg_req_i.wr && reg_req_i.addr == REG_RXQ_ADDR && access_ok && !rxq_load_i)
		##1 (reg_req_i.rd && reg_req_i.addr == REG_RXQ_ADDR && access_ok
		&& !reg_req_i.wr && !rxq_load_i)
		|=> reg_rvalid_o && reg_rdata_o == $past(reg_req_i.wdata, 2))
		else $error("queue byte write not read back");

	// Without the oscillator no answer appears
	a_no_access_idle: assert property ( // [RULE2]
		!access_ok |=> !reg_rvalid_o && !rxq_pop_o)
		else $error("access answered without oscillator");

	// Normal function passes through on code 0
	a_normal_pass: assert property ( // [RULE3]
		clear_channel_pin_select_i == CODE_NORMAL |=> clear_channel_pin_o == $past(clear_channel_i))
		else $error("normal function not on pin");

	// Code 1 shows the I-branch LSB on the frame-delimiter pin
	a_adc_lsb_out: assert property ( // [RULE4]
		frame_delimiter_pin_select_i == CODE_ADC_LSB
		|=> frame_delimiter_pin_o == $past(obs_i.adc_i_lsb))
		else $error("ADC LSB not on pin");

	// A late resync reaches the pin two cycles later
	a_late_pulse_pin: assert property ( // [RULE5]
		(obs_i.demod_late_resync_pulse ##1 clear_channel_pin_select_i == CODE_RESYNC)
		|=> clear_channel_pin_o)
		else $error("late resync pulse missing");

	// The stretched pulse lasts exactly seven core cycles, one 16 MHz period rounded up
	a_early_width: assert property ( // [RULE6]
		obs_i.demod_early_resync_pulse ##1 (!obs_i.demod_early_resync_pulse)[*7]
		|-> early_str ##1 !early_str)
		else $error("early resync pulse width wrong");

	// Lock status mirrored on code 3
	a_lock_mirror: assert property ( // [RULE7]
		frame_delimiter_pin_select_i == CODE_LOCK
		|=> frame_delimiter_pin_o == $past(obs_i.synth_locked_flag))
		else $error("lock status not mirrored");

	// The chip clock on clear-channel code 4 is quiet outside transmission
	a_tx_gate_low: assert property ( // [RULE8]
		(clear_channel_pin_select_i == CODE_TX_CHIP && !obs_i.tx_active) |=> !clear_channel_pin_o)
		else $error("chip clock outside transmission");

	// Power-down group starts with bit 0 on code 6
	a_pd_order: assert property ( // [RULE10]
		frame_delimiter_pin_select_i == CODE_PD_FIRST
		|=> frame_delimiter_pin_o == $past(obs_i.power_down[0]))
		else $error("power-down order wrong");

	// The 8 MHz clock is on the pin for code 23
	a_clk8_pin: assert property ( // [RULE16]
		clear_channel_pin_select_i == CODE_CLK8 |=> clear_channel_pin_o == $past(state_q.clk8))
		else $error("8 MHz clock not on pin");

	// Constant codes, judged per pin so either code alone is enough to trigger
	a_const_levels: assert property ( // [RULE20]
		(clear_channel_pin_select_i == CODE_HIGH || frame_delimiter_pin_select_i == CODE_LOW)
		|=> (clear_channel_pin_o || !$past(clear_channel_pin_select_i == CODE_HIGH))
		&& !(frame_delimiter_pin_o && $past(frame_delimiter_pin_select_i == CODE_LOW)))
		else $error("constant codes wrong");

	// Reserved codes stay low, each pin on its own
	a_reserved_low: assert property ( // [RULE21]
		(clear_channel_pin_select_i inside {[5'h12:5'h16]}
		|| frame_delimiter_pin_select_i inside {[5'h12:5'h17]})
		|=> !(clear_channel_pin_o && $past(clear_channel_pin_select_i inside {[5'h12:5'h16]}))
		&& !(frame_delimiter_pin_o && $past(frame_delimiter_pin_select_i inside {[5'h12:5'h17]})))
		else $error("reserved code not low");

	// Bit-rate data on the frame-delimiter pin is gated by transmission
	a_tx_data_out: assert property ( // [RULE9]
		frame_delimiter_pin_select_i == CODE_TX_BIT
		|=> frame_delimiter_pin_o == $past(obs_i.tx_active & obs_i.tx_bit_stream))
		else $error("bit-rate data not on pin");

	// The late stretcher lasts exactly seven core cycles as well
	a_late_width: assert property ( // [RULE5]
		obs_i.demod_late_resync_pulse ##1 (!obs_i.demod_late_resync_pulse)[*7]
		|-> late_str ##1 !late_str)
		else $error("late resync pulse width wrong");

	// A gain update reaches the pin two cycles later
	a_gain_pulse_pin: assert property ( // [RULE11]
		(obs_i.gain_update_pulse ##1 clear_channel_pin_select_i == 5'h0c)
		|=> clear_channel_pin_o)
		else $error("gain update pulse missing");

	// Peak detector stage 1 on the clear-channel pin
	a_peak_stage_out: assert property ( // [RULE12]
		clear_channel_pin_select_i == 5'h0d
		|=> clear_channel_pin_o == $past(obs_i.peak_det[1]))
		else $error("peak detector stage not on pin");

	// Gain mode bit 0 on the frame-delimiter pin
	a_gain_mode_bit: assert property ( // [RULE13]
		frame_delimiter_pin_select_i == 5'h0f
		|=> frame_delimiter_pin_o == $past(obs_i.frontend_gain_mode[0]))
		else $error("gain mode bit not on pin");

	// VGA gain bit 1 on the clear-channel pin
	a_vga_gain_bit: assert property ( // [RULE13]
		clear_channel_pin_select_i == 5'h10
		|=> clear_channel_pin_o == $past(obs_i.vga_gain[1]))
		else $error("VGA gain bit not on pin");

	// Peak-detector reset keeps its active-low sense on the pin
	a_peak_reset_out: assert property ( // [RULE14]
		clear_channel_pin_select_i == 5'h11
		|=> clear_channel_pin_o == $past(obs_i.peak_det_reset_n))
		else $error("peak reset not on pin");

	// Calibration clock on the frame-delimiter pin
	a_cal_clock_out: assert property ( // [RULE15]
		frame_delimiter_pin_select_i == 5'h11
		|=> frame_delimiter_pin_o == $past(obs_i.bandpass_cal_clock))
		else $error("calibration clock not on pin");

	// Crystal stable flag on the clear-channel pin
	a_crystal_flag_out: assert property ( // [RULE17]
		clear_channel_pin_select_i == 5'h18
		|=> clear_channel_pin_o == $past(obs_i.crystal_stable_flag))
		else $error("crystal flag not on pin");

	// Frequency comparator on the frame-delimiter pin
	a_freq_compare_out: assert property ( // [RULE18]
		frame_delimiter_pin_select_i == 5'h18
		|=> frame_delimiter_pin_o == $past(obs_i.synth_freq_compare))
		else $error("frequency comparator not on pin");

	// Synchronized lock window on the clear-channel pin
	a_lock_window_out: assert property ( // [RULE19]
		clear_channel_pin_select_i == 5'h1c
		|=> clear_channel_pin_o == $past(obs_i.synth_lock_window_sync))
		else $error("lock window not on pin");

	// Main scenarios
	c_queue_read: cover property (
		reg_req_i.rd && hit_rxq && access_ok ##1 reg_rvalid_o);
	c_late_seen: cover property (
		clear_channel_pin_select_i == CODE_RESYNC && clear_channel_pin_o);
	c_clk8_toggle: cover property (
		clear_channel_pin_select_i == CODE_CLK8 ##1 $rose(clear_channel_pin_o));
	c_tx_bit: cover property (
		frame_delimiter_pin_select_i == CODE_TX_BIT && obs_i.tx_active ##1 frame_delimiter_pin_o);
	c_gain_seen: cover property (
		clear_channel_pin_select_i == 5'h0c && clear_channel_pin_o);

endmodule

`default_nettype wire

// file: testbench/tsm_host_model.sv
// Host model that reaches the receive queue byte over the register port.
// Assumes access() is called at a falling edge of core_clk_i.
`timescale 1ns/1ns
`default_nettype none

module tsm_host_model
	import tsm_pkg::*;
(
	// Clock and device status
	input wire logic core_clk_i,
	input wire logic crystal_i,
	// Register port
	output tsm_reg_req_type req_o,
	input wire logic [7:0] rdata_i,
	input wire logic rvalid_i
);
	// Idle until the first access
	initial req_o = '0;

	// One byte access; rogue breaks the oscillator condition on purpose
	task automatic access(input logic wr, input logic [5:0] addr, input logic [7:0] wdata,
		input logic rogue, output logic [7:0] rdata, output logic got);
		int n;
		n = 0;
		// Let an edge pass so the last release and this request never share a time step
		@(negedge core_clk_i);
		// Hold back while the oscillator is not running
		while (!rogue && crystal_i !== 1'b1 && n < 100)
		begin
			@(negedge core_clk_i);
			n++;
		end
		req_o.rd = !wr;
		req_o.wr = wr;
		req_o.addr = addr;
		req_o.wdata = wdata;
		@(negedge core_clk_i);
		// The answer stands one cycle, so it is taken now
		got = rvalid_i;
		rdata = rdata_i;
		// Released strobes go low; address and data show the inverse, never the last value
		req_o.rd = 1'b0;
		req_o.wr = 1'b0;
		req_o.addr = ~addr;
		req_o.wdata = ~wdata;
	endtask

	// Write then read back at the very next edge; the caller keeps the oscillator running
	task automatic write_read(input logic [5:0] addr, input logic [7:0] wdata,
		output logic [7:0] rdata, output logic got);
		@(negedge core_clk_i);
		req_o.rd = 1'b0;
		req_o.wr = 1'b1;
		req_o.addr = addr;
		req_o.wdata = wdata;
		@(negedge core_clk_i);
		// Swap the write strobe for a read; address and data stay put
		req_o.rd = 1'b1;
		req_o.wr = 1'b0;
		@(negedge core_clk_i);
		got = rvalid_i;
		rdata = rdata_i;
		req_o.rd = 1'b0;
		req_o.addr = ~addr;
		req_o.wdata = ~wdata;
	endtask
endmodule

`default_nettype wire

// file: testbench/tb_test_signal_output_mux.sv
// Self-checking bench of the test signal output mux.
// Assumes a 100 MHz core clock; inputs change at falling edges only.
`timescale 1ns/1ns
`default_nettype none

module tb_test_signal_output_mux;
	import tsm_pkg::*;

	logic clk = 1'b0;
	logic resetn = 1'b0;
	tsm_obs_type obs = '0;
	logic [4:0] cca_sel = '0;
	logic [4:0] sfd_sel = '0;
	logic cca_norm = 1'b0;
	logic sfd_norm = 1'b0;
	logic load = 1'b0;
	logic [7:0] load_byte = 8'h00;
	tsm_reg_req_type req;
	logic [7:0] rdata;
	logic rvalid, pop, cca_pin, sfd_pin;
	int miscompares = 0;
	int check_count = 0;
	int cycles = 0;

	tsm_top dut_u (.core_clk_i(clk), .resetn_i(resetn), .reg_req_i(req),
		.reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .rxq_load_i(load),
		.rxq_load_byte_i(load_byte), .rxq_pop_o(pop), .clear_channel_pin_select_i(cca_sel),
		.frame_delimiter_pin_select_i(sfd_sel), .clear_channel_i(cca_norm),
		.frame_delimiter_i(sfd_norm), .obs_i(obs), .clear_channel_pin_o(cca_pin),
		.frame_delimiter_pin_o(sfd_pin));

	tsm_host_model host_u (.core_clk_i(clk), .crystal_i(obs.crystal_stable_flag),
		.req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));

	// 100 MHz core clock
	initial forever #5 clk = ~clk;

	// Hang guard; the tests need well under a thousand cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Compare tasks, one per kind of result
	task automatic check_bit(string what, logic exp, logic got);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected %s: expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic check_byte(string what, logic [7:0] exp, logic [7:0] got);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_range(string what, int lo, int hi, int got);
		check_count++;
		if (got < lo || got > hi)
		begin
			miscompares++;
			$display("unexpected %s: expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask

	// Reset held eight cycles, oscillator running afterwards
	task automatic do_reset();
		resetn = 1'b0;
		repeat (8) @(negedge clk);
		obs.crystal_stable_flag = 1'b1;
		resetn = 1'b1;
	endtask

	// Expected pin level; bit 1 marks a free-running clock not judged here
	function automatic logic [1:0] exp_pin(logic sfd, logic [4:0] c, tsm_obs_type o,
		logic nrm);
		logic v;
		v = 1'b0;
		case (c)
			5'h00: v = nrm;
			5'h01: v = sfd ? o.adc_i_lsb : o.adc_q_lsb;
			5'h03: v = o.synth_locked_flag;
			5'h04: v = o.tx_active & (sfd ? o.tx_chip_stream : o.tx_chip_rate_clock);
			5'h05: v = o.tx_active & (sfd ? o.tx_bit_stream : o.tx_bit_rate_clock);
			5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b: v = o.power_down[3'(c - 5'h06)];
			5'h0c: v = sfd & o.peak_det[0];
			5'h0d: v = sfd ? o.peak_det[2] : o.peak_det[1];
			5'h0e: v = sfd ? o.peak_det[4] : o.peak_det[3];
			5'h0f: v = o.frontend_gain_mode[!sfd];
			5'h10: v = o.vga_gain[!sfd];
			5'h11: v = sfd ? o.bandpass_cal_clock : o.peak_det_reset_n;
			5'h17: return {!sfd, 1'b0};
			5'h18: v = sfd ? o.synth_freq_compare : o.crystal_stable_flag;
			5'h19: v = o.synth_reference_signal;
			5'h1a: v = o.synth_divided_signal;
			5'h1b: v = o.synth_lock_window;
			5'h1c: v = o.synth_lock_window_sync;
			5'h1d: v = sfd ? o.converter_clock_two : o.converter_clock_one;
			5'h1f: v = 1'b1;
			default: v = 1'b0;
		endcase
		return {1'b0, v};
	endfunction

	// Queue byte: reset value, write/read, unmapped, refused, load, second reset
	task automatic reg_test();
		logic [7:0] d;
		logic g;
		host_u.access(1'b0, REG_RXQ_ADDR, 8'h00, 1'b0, d, g);
		check_byte("queue after reset", 8'h00, d);
		host_u.access(1'b1, REG_RXQ_ADDR, 8'h77, 1'b0, d, g);
		host_u.access(1'b0, REG_RXQ_ADDR, 8'h00, 1'b0, d, g);
		check_byte("queue read", 8'h77, d);
		check_bit("read answer", 1'b1, g);
		check_bit("pop on read", 1'b1, pop);
		// Back-to-back write and read: the read sees the new byte
		host_u.write_read(REG_RXQ_ADDR, 8'ha5, d, g);
		check_byte("queue write then read", 8'ha5, d);
		check_bit("back-to-back answer", 1'b1, g);
		check_bit("pop on back-to-back read", 1'b1, pop);
		host_u.access(1'b0, 6'h10, 8'h00, 1'b0, d, g);
		check_byte("unmapped read", 8'h00, d);
		check_bit("pop on unmapped", 1'b0, pop);
		// Oscillator stopped: the device drops the access
		obs.crystal_stable_flag = 1'b0;
		host_u.access(1'b1, REG_RXQ_ADDR, 8'h5a, 1'b1, d, g);
		host_u.access(1'b0, REG_RXQ_ADDR, 8'h00, 1'b1, d, g);
		check_bit("answer without oscillator", 1'b0, g);
		obs.crystal_stable_flag = 1'b1;
		host_u.access(1'b0, REG_RXQ_ADDR, 8'h00, 1'b0, d, g);
		check_byte("queue kept", 8'ha5, d);
		// Receive path load
		load = 1'b1;
		load_byte = 8'h3c;
		@(negedge clk);
		load = 1'b0;
		host_u.access(1'b0, REG_RXQ_ADDR, 8'h00, 1'b0, d, g);
		check_byte("loaded byte", 8'h3c, d);
		do_reset();
		host_u.access(1'b0, REG_RXQ_ADDR, 8'h00, 1'b0, d, g);
		check_byte("queue after second reset", 8'h00, d);
	endtask

	// Every code on both pins against four source patterns, except code 23 on the clear-channel pin
	task automatic pin_table_test();
		logic [35:0] pats [4];
		logic [1:0] e;
		pats = '{36'h9a5c36e1b, 36'h65a3c91e4, 36'hc3a5f0963, 36'h3c5a0f69c};
		for (int k = 0; k < 4; k++)
		begin
			for (int c = 0; c < 32; c++)
			begin
				obs = tsm_obs_type'(pats[k]);
				obs.demod_late_resync_pulse = 1'b0;
				obs.demod_early_resync_pulse = 1'b0;
				obs.gain_update_pulse = 1'b0;
				cca_norm = k[0];
				sfd_norm = !k[0];
				cca_sel = 5'(c);
				sfd_sel = 5'(31 - c);
				repeat (2) @(negedge clk);
				e = exp_pin(1'b0, cca_sel, obs, cca_norm);
				if (!e[1])
					check_bit("clear-channel pin", e[0], cca_pin);
				e = exp_pin(1'b1, sfd_sel, obs, sfd_norm);
				if (!e[1])
					check_bit("frame-delimiter pin", e[0], sfd_pin);
			end
		end
	endtask

	// One source strobe must give a pulse of one 16 MHz cycle on the pin
	task automatic pulse_test(logic [4:0] code, int kind);
		int hc, hs;
		hc = 0;
		hs = 0;
		obs = '0;
		obs.crystal_stable_flag = 1'b1;
		cca_sel = code;
		sfd_sel = code;
		repeat (10) @(negedge clk);
		obs.demod_late_resync_pulse = (kind == 0);
		obs.demod_early_resync_pulse = (kind == 0);
		obs.gain_update_pulse = (kind == 1);
		@(negedge clk);
		obs = '0;
		obs.crystal_stable_flag = 1'b1;
		repeat (12)
		begin
			@(negedge clk);
			hc += (cca_pin === 1'b1);
			hs += (sfd_pin === 1'b1);
		end
		check_range("clear-channel pulse", int'(PULSE_CYCLES), int'(PULSE_CYCLES), hc);
		check_range("frame-delimiter pulse", kind == 0 ? int'(PULSE_CYCLES) : 0,
			kind == 0 ? int'(PULSE_CYCLES) : 0, hs);
	endtask

	// 8 MHz output: 32 toggles in 200 core cycles, one either way for jitter
	task automatic clock8_test();
		int n;
		logic prev;
		n = 0;
		cca_sel = CODE_CLK8;
		repeat (4) @(negedge clk);
		prev = cca_pin;
		repeat (200)
		begin
			@(negedge clk);
			n += (cca_pin !== prev);
			prev = cca_pin;
		end
		check_range("8 MHz toggles", 31, 33, n);
	endtask

	initial
	begin
		do_reset();
		reg_test();
		pin_table_test();
		pulse_test(CODE_RESYNC, 0);
		pulse_test(5'h0c, 1);
		clock8_test();
		tally_and_finish();
	end
endmodule

`default_nettype wire
